// file: sefe_buf.sv
/*
 two-entry valid/ready buffer for written words.
 assumes both sides on the same clock.
*/
`default_nettype none
module sefe_buf
	import sefe_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire sefe_word_s in_word,
	output logic out_valid,
	input wire logic out_ready,
	output sefe_word_s out_word
);
	sefe_word_s mem [2];
	logic [1:0] cnt;
	logic rd_ptr;
	logic wr_ptr;
	logic [1:0] next_cnt;
	logic next_rd_ptr;
	logic next_wr_ptr;
	logic push;
	logic pop;

	// honest full and empty straight from the count
	assign in_ready = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign out_word = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb
	begin
		next_cnt = cnt + {1'b0, push} - {1'b0, pop};
		next_rd_ptr = rd_ptr ^ pop;
		next_wr_ptr = wr_ptr ^ push;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 2'h0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
		end
	end

	// storage has no reset, contents only read while valid
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_word;
		end
	end
endmodule // sefe_buf
`default_nettype wire

// file: sefe_host.sv
/*
 host model: two-wire bus master, open-drain data, clock idles high.
 assumes the bench resolves the data line with a pull-up.
*/
`default_nettype none
module sefe_host
(
	output var logic scl,
	output var logic pull,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q = 40; // quarter of the 160 ns link period

	// idle: clock parked high, data released
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end

	// one clock during reset so the link side sees an edge
	task automatic pulse();
		#Q scl = 1'b0;
		#Q scl = 1'b1;
	endtask

	// works from idle or from a clock-low gap
	task automatic start();
		#Q pull = 1'b0;
		#Q scl = 1'b1;
		#Q pull = 1'b1;
		#(2*Q) scl = 1'b0;
	endtask

	// clock then stands still high
	task automatic stop();
		#Q pull = 1'b1;
		#Q scl = 1'b1;
		#Q pull = 1'b0;
	endtask

	// data set while clock low, sampled mid-high
	task automatic clk_bit(input logic b, output logic s);
		#Q pull = !b;
		#Q scl = 1'b1;
		#Q s = sda;
		#Q scl = 1'b0;
	endtask

	// msb first, ninth clock reads the answer
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask

	// host acks or releases on the ninth clock
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(!ack, s);
	endtask
endmodule // sefe_host
`default_nettype wire

// file: sefe_pkg.sv
/*
 package of the secure eeprom two-wire front end: timing, zone layout,
 states and the word carrier. assumes a 20 MHz system clock.
*/
`default_nettype none
package sefe_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int WR_TIME_MS = 5;
	localparam int WR_CYCLES = (CLK_HZ / 1000) * WR_TIME_MS;
	localparam int WORD_BITS = 8;
	localparam int ZONE_COUNT = 4;
	localparam int ZONE_BYTES = 32;
	localparam int ZONE_BITS = 256;
	localparam int MEM_BYTES = ZONE_COUNT * ZONE_BYTES;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [ZONE_COUNT-1:0] ZONE_OPEN_RST = 4'h0;
	localparam logic [1:0] ZONE_GRP_RST = 2'h0;

	typedef enum logic [2:0] {
		SEFE_IDLE = 3'h0,
		SEFE_CMD = 3'h1,
		SEFE_ADDR = 3'h3,
		SEFE_WDATA = 3'h2,
		SEFE_RDATA = 3'h6,
		SEFE_SKIP = 3'h7
	} sefe_state_e;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} sefe_word_s;
endpackage
`default_nettype wire

// file: sefe_top.sv
/*
 secure eeprom two-wire front end: bit engine on the serial clock,
 write engine and user memory on clk.
 assumes an external pull-up on the data line and a host as bus master.
*/
// Behaviour
// R1: host changes data only while serial clock is low.
// R2: data edge with clock high is start or stop, never data.
// R3: falling data with clock high is start; command reception begins.
// R4: rising data with clock high is stop; after read enter standby.
// R5: every address and data word is eight bits.
// R6: device pulls data low on ninth clock after each received word.
// R7: host recovers by start plus command, polling for acknowledge.
// R8: internal write finishes within 5 ms after stop ending write.
// R9: user memory is four zones of 32 bytes each.
// R10: access to zone refused until its security is satisfied.
// R11: zones with equal security may be accessed as one.
// R12: sample on rising clock edge, change output after falling edge.
// R13: data line driven open-drain only, low or released.
// R14: release data line unless acknowledging or sending a bit.
// R15: no acknowledge to command while internal write is busy.
`default_nettype none
module sefe_top
	import sefe_pkg::*;
#(
	parameter int WR_CYCLES_P = WR_CYCLES
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [ZONE_COUNT-1:0] zone_open,
	input wire logic [2*ZONE_COUNT-1:0] zone_group,
	output logic write_busy,
	output logic standby
);
	// link domain state
	sefe_state_e state;
	sefe_state_e next_state;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [6:0] addr;
	logic [6:0] next_addr;
	logic rd_cmd;
	logic next_rd_cmd;
	logic ack_drv;
	logic next_ack_drv;
	logic out_drv;
	logic next_out_drv;
	logic push_tgl;
	logic next_push_tgl;
	logic [7:0] wdata;
	logic [7:0] next_wdata;
	logic [6:0] waddr;
	logic [6:0] next_waddr;
	logic start_tgl;
	logic stop_ev_tgl;
	logic start_seen;
	logic stop_seen;
	logic busy_l1;
	logic busy_l2;
	logic [ZONE_COUNT-1:0] open_l1;
	logic [ZONE_COUNT-1:0] open_l2;
	logic [7:0] rd_byte;

	// start and stop are seen on data edges while the serial clock is high
	always_ff @(negedge sda_i or negedge arst_n)
	begin
		if (!arst_n)
			start_tgl <= 1'b0;
		else if (scl_clk) // R2 R3
			start_tgl <= ~start_tgl;
	end

	always_ff @(posedge sda_i or negedge arst_n)
	begin
		if (!arst_n)
			stop_ev_tgl <= 1'b0;
		else if (scl_clk) // R2 R4
			stop_ev_tgl <= ~stop_ev_tgl;
	end

	// the bit engine consumes the toggles; it tracks what it last acted on
	logic start_ack;
	logic next_start_ack;
	logic stop_ack;
	logic next_stop_ack;
	assign start_seen = start_tgl ^ start_ack;
	assign stop_seen = stop_ev_tgl ^ stop_ack;

	// busy and zone_open reach the link clock through two flops each; zone_group is used directly
	always_ff @(posedge scl_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy_l1 <= 1'b0;
			busy_l2 <= 1'b0;
			open_l1 <= ZONE_OPEN_RST;
			open_l2 <= ZONE_OPEN_RST;
		end
		else
		begin
			busy_l1 <= write_busy;
			busy_l2 <= busy_l1;
			open_l1 <= zone_open;
			open_l2 <= open_l1;
		end
	end

	// zone gating: a zone opens if it, or a zone sharing its group, is open
	logic [ZONE_COUNT-1:0] zone_ok;
	genvar gz;
	generate
		for (gz = 0; gz < ZONE_COUNT; gz++)
		begin : g_zone
			logic [ZONE_COUNT-1:0] same;
			genvar gk;
			for (gk = 0; gk < ZONE_COUNT; gk++)
			begin : g_peer
				assign same[gk] = (zone_group[2*gk +: 2] == zone_group[2*gz +: 2]) & open_l2[gk]; // R11
			end
			assign zone_ok[gz] = |same; // R10
		end
	endgenerate

	logic addr_ok;
	assign addr_ok = zone_ok[addr[6:5]]; // R9 R10

	// bit engine next values, sampled on the rising serial edge
	always_comb
	begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_addr = addr;
		next_rd_cmd = rd_cmd;
		next_push_tgl = push_tgl;
		next_wdata = wdata;
		next_waddr = waddr;
		next_start_ack = start_ack;
		next_stop_ack = stop_ack;
		if (stop_seen)
		begin
			// the clk side times the write itself: the serial clock stops after a stop
			next_stop_ack = stop_ev_tgl;
			next_state = SEFE_IDLE;
		end
		if (start_seen)
		begin
			next_start_ack = start_tgl;
			// the first rising edge after a start already carries the first bit
			next_state = SEFE_CMD; // R3
			next_bitcnt = 4'h1;
			next_shreg = {shreg[6:0], sda_i}; // R12
			next_rd_cmd = 1'b0;
		end
		if (!start_seen && next_state != SEFE_IDLE && state != SEFE_IDLE)
		begin
			next_bitcnt = (bitcnt == BIT_ACK) ? 4'h0 : bitcnt + 4'h1; // R5
			if (bitcnt < BIT_ACK)
				next_shreg = {shreg[6:0], sda_i}; // R12
			if (bitcnt == BIT_ACK)
			begin
				unique case (state)
					SEFE_CMD:
						if (busy_l2)
							next_state = SEFE_SKIP; // R15
						else
						begin
							next_rd_cmd = shreg[0];
							next_state = SEFE_ADDR;
						end
					SEFE_ADDR:
					begin
						next_addr = shreg[6:0];
						next_state = rd_cmd ? SEFE_RDATA : SEFE_WDATA;
					end
					SEFE_WDATA:
					begin
						if (addr_ok)
						begin
							next_wdata = shreg;
							next_waddr = addr;
							next_push_tgl = ~push_tgl;
						end
						next_addr = addr + 7'h01;
					end
					SEFE_RDATA:
					begin
						next_addr = addr + 7'h01;
						if (sda_i)
							next_state = SEFE_SKIP; // host nack ends the read
					end
					SEFE_SKIP:
						next_state = SEFE_SKIP;
					default:
						next_state = SEFE_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge scl_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= SEFE_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			addr <= 7'h00;
			rd_cmd <= 1'b0;
			push_tgl <= 1'b0;
			wdata <= 8'h00;
			waddr <= 7'h00;
			start_ack <= 1'b0;
			stop_ack <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			addr <= next_addr;
			rd_cmd <= next_rd_cmd;
			push_tgl <= next_push_tgl;
			wdata <= next_wdata;
			waddr <= next_waddr;
			start_ack <= next_start_ack;
			stop_ack <= next_stop_ack;
		end
	end

	// output drive changes on the falling serial edge
	always_comb
	begin
		next_ack_drv = 1'b0;
		next_out_drv = 1'b0;
		if (bitcnt == BIT_ACK && !start_seen && !stop_seen)
		begin
			unique case (state)
				SEFE_CMD: next_ack_drv = ~busy_l2; // R6 R15
				SEFE_ADDR: next_ack_drv = 1'b1; // R6
				SEFE_WDATA: next_ack_drv = addr_ok; // R6 R10
				default: next_ack_drv = 1'b0;
			endcase
		end
		if (state == SEFE_RDATA && bitcnt < BIT_ACK && addr_ok)
			next_out_drv = ~rd_byte[3'd7 - bitcnt[2:0]]; // R10 R12
	end

	always_ff @(negedge scl_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_drv <= 1'b0;
			out_drv <= 1'b0;
		end
		else
		begin
			ack_drv <= next_ack_drv;
			out_drv <= next_out_drv;
		end
	end

	// open-drain: only ever pull low, otherwise release
	assign sda_o = 1'b0; // R13
	assign sda_oe = ack_drv | out_drv; // R13 R14

	// system domain: toggle crossings for pushes and stops
	logic [2:0] push_sync;
	logic [2:0] stop_sync;
	logic [2:0] rds_sync;
	logic [7:0] mem [MEM_BYTES];
	logic [31:0] wr_cnt;
	logic [31:0] next_wr_cnt;
	logic next_write_busy;
	logic next_standby;
	logic pend;
	logic next_pend;
	sefe_word_s buf_in;
	sefe_word_s buf_out;
	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic stop_ev;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			push_sync <= 3'h0;
			stop_sync <= 3'h0;
			rds_sync <= 3'h0;
		end
		else
		begin
			push_sync <= {push_sync[1:0], push_tgl};
			stop_sync <= {stop_sync[1:0], stop_ev_tgl};
			rds_sync <= {rds_sync[1:0], rd_cmd};
		end
	end

	// word is stable long before its toggle lands, so sampled with it
	assign buf_in = '{addr: waddr, data: wdata};
	assign buf_in_valid = push_sync[2] ^ push_sync[1];
	assign buf_out_ready = 1'b1;

	sefe_buf u_buf (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_word(buf_in),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_word(buf_out)
	);

	// write timer: busy from the stop until the count runs out
	always_comb
	begin
		next_wr_cnt = wr_cnt;
		next_write_busy = write_busy;
		next_standby = standby;
		next_pend = pend | (buf_out_valid & buf_out_ready);
		// a stop without stored data, e.g. while polling, leaves the timer alone
		if (stop_ev && next_pend)
		begin
			next_write_busy = 1'b1; // R8
			next_wr_cnt = 32'h0000_0000;
			next_pend = 1'b0;
		end
		else if (write_busy)
		begin
			next_wr_cnt = wr_cnt + 32'h0000_0001;
			if (wr_cnt == 32'(WR_CYCLES_P - 1))
				next_write_busy = 1'b0; // R8
		end
		if (stop_ev)
			next_standby = rds_sync[2]; // R4
		if (buf_in_valid)
			next_standby = 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_cnt <= 32'h0000_0000;
			write_busy <= 1'b0;
			standby <= 1'b0;
			pend <= 1'b0;
		end
		else
		begin
			wr_cnt <= next_wr_cnt;
			write_busy <= next_write_busy;
			standby <= next_standby;
			pend <= next_pend;
		end
	end

	// user memory, four zones of 32 bytes; read path crosses as a quasi-static word
	always_ff @(posedge clk)
	begin
		if (buf_out_valid & buf_out_ready)
			mem[buf_out.addr] <= buf_out.data; // R9
	end

	assign rd_byte = mem[addr]; // limitation: addr held stable through the read word
	// read mode is long settled when the stop arrives, so its level is taken
	assign stop_ev = stop_sync[2] ^ stop_sync[1];

	AST_WRITE_BOUNDED: assert property (@(posedge clk) disable iff (!arst_n)
		write_busy |-> wr_cnt < 32'(WR_CYCLES_P)) // R8
		else $error("write cycle overran");
	AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!arst_n)
		sda_o == 1'b0) // R13
		else $error("data line driven high");
	AST_NO_ACK_BUSY: assert property (@(negedge scl_clk) disable iff (!arst_n)
		(state == SEFE_SKIP && bitcnt == 4'h0) |-> !ack_drv) // R15
		else $error("acknowledge while busy");
	AST_ACK_NINTH: assert property (@(negedge scl_clk) disable iff (!arst_n)
		ack_drv |-> $past(bitcnt) == BIT_ACK) // R6
		else $error("acknowledge off the ninth clock");
	AST_RELEASE: assert property (@(posedge scl_clk) disable iff (!arst_n)
		state == SEFE_IDLE |-> !out_drv) // R14
		else $error("line held while idle");
	AST_START_CMD: assert property (@(posedge scl_clk) disable iff (!arst_n)
		start_seen |=> state == SEFE_CMD && bitcnt == 4'h1) // R3
		else $error("start did not begin a command");
	AST_WORD_LEN: assert property (@(posedge scl_clk) disable iff (!arst_n)
		bitcnt <= BIT_ACK) // R5
		else $error("bit counter past ninth bit");
	AST_REFUSE: assert property (@(negedge scl_clk) disable iff (!arst_n)
		(out_drv && state == SEFE_RDATA) |-> $past(addr_ok)) // R10
		else $error("closed zone read");
endmodule // sefe_top
`default_nettype wire

// file: sefe_top_bench.sv
/*
 self-checking bench of the front end with a host model.
 assumes the design's own assertions and a 50-cycle write time.
*/
`default_nettype none
module sefe_top_bench;
	import sefe_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WRC = 50;
	logic clk;
	logic arst_n;
	logic scl;
	logic pull;
	logic sda_o;
	logic sda_oe;
	logic [ZONE_COUNT-1:0] zone_open;
	logic [2*ZONE_COUNT-1:0] zone_group;
	logic write_busy;
	logic standby;
	wire logic sda_line;
	int n_mismatch;
	int cmp_count;

	// pull-up wins unless someone pulls low
	assign sda_line = !(pull || (sda_oe && !sda_o));

	sefe_host host (.scl(scl), .pull(pull), .sda(sda_line));

	sefe_top #(.WR_CYCLES_P(WRC)) uut (
		.clk(clk),
		.arst_n(arst_n),
		.scl_clk(scl),
		.sda_i(sda_line),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.zone_open(zone_open),
		.zone_group(zone_group),
		.write_busy(write_busy),
		.standby(standby)
	);

	// 20 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// zone settings change just after a clk edge
	task automatic zones(input logic [3:0] o, input logic [7:0] g);
		@(posedge clk);
		#2 zone_open = o;
		zone_group = g;
	endtask

	task automatic sb(input logic [7:0] d, input logic exp);
		logic a;
		host.send_byte(d, a);
		check({7'h0, a}, {7'h0, exp});
	endtask

	task automatic rb(input logic [7:0] exp, input logic ack);
		logic [7:0] d;
		host.recv_byte(ack, d);
		check(d, exp);
	endtask

	task automatic stop_chk();
		host.stop();
		check({7'h0, sda_oe}, 8'h00);
	endtask

	// single write, then the internal write is timed
	task automatic t_write();
		int n;
		int hi;
		n = 0;
		hi = 0;
		zones(4'hF, 8'h00);
		host.start();
		sb(8'hA0, 1'b1);
		sb(8'h05, 1'b1);
		sb(8'h5A, 1'b1);
		stop_chk();
		while (write_busy !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		while (write_busy === 1'b1 && n < WRC + 40)
		begin
			@(posedge clk);
			n++;
			hi++;
		end
		check({7'h0, n <= WRC + 10 && hi >= WRC - 2}, 8'h01);
	endtask

	// burst over a zone seam, poll while busy, read it back
	task automatic t_poll();
		logic a;
		int k;
		k = 0;
		zones(4'hF, 8'h16); // zones 1 and 2 share a group
		host.start();
		sb(8'hA0, 1'b1);
		sb(8'h3F, 1'b1);
		sb(8'h11, 1'b1);
		sb(8'h22, 1'b1);
		host.stop();
		host.start();
		sb(8'hA1, 1'b0);
		do
		begin
			host.stop();
			host.start();
			host.send_byte(8'hA1, a);
			k++;
		end
		while (a !== 1'b1 && k < 10);
		check({7'h0, write_busy}, 8'h00);
		sb(8'h3F, 1'b1);
		rb(8'h11, 1'b1);
		rb(8'h22, 1'b0);
		stop_chk();
		k = 0;
		while (standby !== 1'b1 && k < 20)
		begin
			@(posedge clk);
			k++;
		end
		check({7'h0, standby}, 8'h01);
	endtask

	// closed zone refuses both ways, reopened zone kept its data
	task automatic t_closed();
		zones(4'hE, 8'h16);
		host.start();
		sb(8'hA0, 1'b1);
		sb(8'h05, 1'b1);
		sb(8'hC3, 1'b0);
		host.stop();
		host.start();
		sb(8'hA1, 1'b1);
		sb(8'h05, 1'b1);
		rb(8'hFF, 1'b0);
		stop_chk();
		zones(4'hF, 8'h16);
		host.start();
		sb(8'hA1, 1'b1);
		sb(8'h05, 1'b1);
		rb(8'h5A, 1'b0);
		stop_chk();
	endtask

	// data line is only ever pulled low
	always @(posedge clk)
		if (arst_n === 1'b1)
			check({7'h0, sda_o}, 8'h00);

	// hang guard, well beyond the expected run
	initial
	begin
		#2_000_000;
		n_mismatch++;
		finish_test();
	end

	initial
	begin
		n_mismatch = 0;
		cmp_count = 0;
		arst_n = 1'b0;
		zone_open = 4'h0;
		zone_group = 8'h00;
		host.pulse();
		repeat (20) @(posedge clk);
		#2 arst_n = 1'b1;
		t_write();
		t_poll();
		t_closed();
		finish_test();
	end
endmodule // sefe_top_bench
`default_nettype wire
